// ==== logic/exs_pkg.sv ====
/*
 * Constants shared by the extended X.21 sync channel: characters, command codes, reset values.
 * Assumes a byte-wide host side and a bit-serial line clocked by a one-cycle enable.
 */
package exs_pkg;
	localparam logic [7:0] EXS_SYNC_CHAR = 8'h16;
	localparam logic [7:0] EXS_CMD_START = 8'h80;
	localparam logic [7:0] EXS_REQ_OFF = 8'h00;
	localparam logic [7:0] EXS_REQ_ON = 8'h01;
	localparam logic [1:0] EXS_MIN_REPEAT = 2'h3;
	localparam logic [7:0] EXS_SPECIAL_RESET = 8'h00;
	localparam int EXS_SPECIAL_COUNT = 3;
	localparam int EXS_BIT_MSB = 7;

	typedef enum logic [4:0] {
		EXS_TX_DATA = 5'h01,
		EXS_TX_CMD_REQ = 5'h02,
		EXS_TX_CMD_CHAR = 5'h04,
		EXS_TX_CMD_COUNT = 5'h08,
		EXS_TX_REPEAT = 5'h10
	} exs_tx_state_t;
endpackage : exs_pkg

// ==== logic/exs_sync_match.sv ====
/*
 * Holds the receive sync character and compares a received byte with it and with the special characters given on the inputs.
 * Assumes writes come from host logic on the same clock.
 */
`timescale 1ns/1ps
module exs_sync_match
	import exs_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic init_pulse,
	input wire logic sync_wr,
	input wire logic [7:0] sync_wdata,
	input wire logic [7:0] special_char_values [EXS_SPECIAL_COUNT],
	input wire logic [7:0] rx_byte,
	output logic [7:0] sync_char_register,
	output logic is_sync,
	output logic [EXS_SPECIAL_COUNT-1:0] is_special
);
	logic [7:0] next_sync;

	always_comb begin
		next_sync = sync_char_register;
		if (init_pulse) begin
			next_sync = EXS_SYNC_CHAR; // [RULE_09]
		end else if (sync_wr) begin
			next_sync = sync_wdata; // [RULE_09]
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sync_char_register <= EXS_SYNC_CHAR;
		end else begin
			sync_char_register <= next_sync;
		end
	end

	assign is_sync = (rx_byte == sync_char_register);

	genvar gi;
	generate
		for (gi = 0; gi < EXS_SPECIAL_COUNT; gi++) begin : g_special
			assign is_special[gi] = (rx_byte == special_char_values[gi]);
		end
	endgenerate
endmodule : exs_sync_match

// ==== logic/exs_channel.sv ====
/*
 * One extended X.21 character-synchronous channel: transmit with escape commands and idle fill,
 * receive with sync hunt, sync/special interrupts and stripping.
 * Assumes host byte streams are on clk; the serial receive data pin is asynchronous and bit_en
 * is a one-cycle enable from an external divider at the line bit rate.
 */
`timescale 1ns/1ps
// What this block does
// [RULE_01] Without escape mode, host bytes go out unchanged.
// [RULE_02] Empty transmit queue sends sync character 16 hex repeatedly.
// [RULE_03] In escape mode, byte 80 hex and next three form one command.
// [RULE_04] Second command byte: 00 request line high, 01 low, others reserved.
// [RULE_05] Third command byte sent as plain eight bits, no parity added.
// [RULE_06] Fourth byte is repeat count; zero repeats until new data.
// [RULE_07] Zero count still sends the character at least three times.
// [RULE_08] Host writes 80 00 FF 00 to idle mark, 80 01 80 01 for literal.
// [RULE_09] Initialization loads sync register with 16 hex; host may change it.
// [RULE_10] Host reprograms sync value only after init, parity bit clear.
// [RULE_11] Sync on one or two sync characters per single-sync select.
// [RULE_12] No end-of-frame delimiter; host decides frame and buffer bounds.
// [RULE_13] Pass characters before and after sync; interrupt on sync detect.
// [RULE_14] Double-sync mode interrupts right after the second sync character.
// [RULE_15] Single-sync mode interrupts right after the one sync character.
// [RULE_16] Without steady-state detect, nothing is stripped from receive data.
// [RULE_17] Strip and special enables act only with steady-state detect set.
// [RULE_18] Sync stripping: after two syncs, special interrupt, strip further syncs.
// [RULE_19] Special char seen twice raises interrupt; further repeats stripped.
// [RULE_20] Exhausted nonzero count with no data returns to idle sync.
module exs_channel
	import exs_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic bit_en,
	input wire logic channel_init,
	input wire logic escape_command_mode,
	input wire logic steady_state_detect_enable,
	input wire logic single_sync_select,
	input wire logic sync_strip_enable,
	input wire logic special_char_detect_enable,
	input wire logic [7:0] special_char_values [EXS_SPECIAL_COUNT],
	input wire logic sync_wr,
	input wire logic [7:0] sync_wdata,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	output logic tx_ready,
	output logic txd,
	output logic request_n,
	input wire logic rxd,
	output logic rx_valid,
	output logic [7:0] rx_data,
	output logic sync_irq,
	output logic special_irq,
	output logic [7:0] sync_char_register
);
	// ************************************************************
	// Transmit
	// ************************************************************
	exs_tx_state_t tx_state, next_tx_state;
	logic [7:0] shreg, next_shreg;
	logic [2:0] bitcnt, next_bitcnt;
	logic [7:0] rep_char, next_rep_char;
	logic [7:0] rep_count, next_rep_count;
	logic [1:0] min_count, next_min_count;
	logic next_request_n;
	logic next_tx_ready;
	logic next_txd;
	logic char_end;

	// A new character is picked at the last bit of the current one
	assign char_end = bit_en && (bitcnt == 3'h7);

	always_comb begin
		next_tx_state = tx_state;
		next_shreg = shreg;
		next_bitcnt = bitcnt;
		next_rep_char = rep_char;
		next_rep_count = rep_count;
		next_min_count = min_count;
		next_request_n = request_n;
		next_tx_ready = 1'b0;
		next_txd = txd;
		if (bit_en) begin
			next_txd = shreg[0];
			next_shreg = {1'b0, shreg[EXS_BIT_MSB:1]};
			next_bitcnt = bitcnt + 3'h1;
		end
		// Idle fill is the default at every boundary, so command bytes never leave zeros on the line
		if (char_end) begin
			next_shreg = EXS_SYNC_CHAR; // [RULE_02]
		end
		// Command bytes are taken immediately except during a repeat, where byte 80 hex waits too; data characters wait for a slot
		case (tx_state)
			EXS_TX_CMD_REQ: begin
				if (tx_valid && !tx_ready) begin
					next_tx_ready = 1'b1;
					if (tx_data == EXS_REQ_OFF) begin
						next_request_n = 1'b1; // [RULE_04]
					end else if (tx_data == EXS_REQ_ON) begin
						next_request_n = 1'b0; // [RULE_04]
					end
					next_tx_state = EXS_TX_CMD_CHAR;
				end
			end
			EXS_TX_CMD_CHAR: begin
				if (tx_valid && !tx_ready) begin
					next_tx_ready = 1'b1;
					next_rep_char = tx_data; // [RULE_05]
					next_tx_state = EXS_TX_CMD_COUNT;
				end
			end
			EXS_TX_CMD_COUNT: begin
				if (tx_valid && !tx_ready) begin
					next_tx_ready = 1'b1;
					next_rep_count = tx_data; // [RULE_06]
					next_min_count = 2'h0;
					next_tx_state = EXS_TX_REPEAT;
				end
			end
			EXS_TX_REPEAT: begin
				if (char_end) begin
					if (rep_count == 8'h00) begin
						// Zero count: stop only once three copies went out and data waits
						if (min_count == EXS_MIN_REPEAT && tx_valid && !tx_ready) begin // [RULE_07]
							next_tx_state = EXS_TX_DATA;
							// A new escape command is left for the data state to take next cycle
							if (!(escape_command_mode && tx_data == EXS_CMD_START)) begin
								next_tx_ready = 1'b1;
								next_shreg = tx_data; // [RULE_01]
							end
						end else begin
							next_shreg = rep_char; // [RULE_06]
							if (min_count != EXS_MIN_REPEAT) begin
								next_min_count = min_count + 2'h1; // [RULE_07]
							end
						end
					end else begin
						next_shreg = rep_char;
						next_rep_count = rep_count - 8'h01;
						if (rep_count == 8'h01) begin
							next_tx_state = EXS_TX_DATA; // [RULE_20]
						end
					end
				end
			end
			EXS_TX_DATA: begin
				if (escape_command_mode && tx_valid && !tx_ready && tx_data == EXS_CMD_START) begin
					next_tx_ready = 1'b1; // [RULE_03]
					next_tx_state = EXS_TX_CMD_REQ;
				end else if (char_end) begin
					if (tx_valid && !tx_ready) begin
						next_tx_ready = 1'b1;
						next_shreg = tx_data; // [RULE_01]
					end else begin
						next_shreg = EXS_SYNC_CHAR; // [RULE_02] [RULE_20]
					end
				end
			end
			default: begin
				next_tx_state = EXS_TX_DATA;
			end
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tx_state <= EXS_TX_DATA;
			shreg <= EXS_SYNC_CHAR;
			bitcnt <= 3'h0;
			rep_char <= 8'h00;
			rep_count <= 8'h00;
			min_count <= 2'h0;
			request_n <= 1'b1;
			tx_ready <= 1'b0;
			txd <= 1'b1;
		end else begin
			tx_state <= next_tx_state;
			shreg <= next_shreg;
			bitcnt <= next_bitcnt;
			rep_char <= next_rep_char;
			rep_count <= next_rep_count;
			min_count <= next_min_count;
			request_n <= next_request_n;
			tx_ready <= next_tx_ready;
			txd <= next_txd;
		end
	end

	// ************************************************************
	// Receive
	// ************************************************************
	logic rxd_meta, rxd_sync;
	logic [7:0] rx_shift, next_rx_shift;
	logic [2:0] rx_cnt, next_rx_cnt;
	logic locked, next_locked;
	logic seen_one, next_seen_one;
	logic [7:0] last_char, next_last_char;
	logic run_hit, next_run_hit;
	logic repeat_hit;
	logic next_rx_valid, next_sync_irq, next_special_irq;
	logic [7:0] next_rx_data;
	logic [7:0] cand;
	logic is_sync;
	logic [EXS_SPECIAL_COUNT-1:0] is_special;
	logic strip_sync_on, special_on;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rxd_meta <= 1'b1;
			rxd_sync <= 1'b1;
		end else begin
			rxd_meta <= rxd;
			rxd_sync <= rxd_meta;
		end
	end

	// LSB first; while hunting every bit shift is a candidate
	assign cand = {rxd_sync, rx_shift[EXS_BIT_MSB:1]};
	assign strip_sync_on = steady_state_detect_enable && sync_strip_enable; // [RULE_16] [RULE_17]
	assign special_on = steady_state_detect_enable && special_char_detect_enable; // [RULE_16] [RULE_17]
	// A stripped run needs a sync or special character equal to the one before it, after lock
	assign repeat_hit = locked && (cand == last_char) && ((is_sync && strip_sync_on) || ((|is_special) && special_on));

	exs_sync_match u_match (
		.clk(clk),
		.nrst(nrst),
		.init_pulse(channel_init),
		.sync_wr(sync_wr),
		.sync_wdata(sync_wdata),
		.special_char_values(special_char_values),
		.rx_byte(cand),
		.sync_char_register(sync_char_register),
		.is_sync(is_sync),
		.is_special(is_special)
	);

	always_comb begin
		next_rx_shift = rx_shift;
		next_rx_cnt = rx_cnt;
		next_locked = locked;
		next_seen_one = seen_one;
		next_last_char = last_char;
		next_run_hit = run_hit;
		next_rx_valid = 1'b0;
		next_rx_data = rx_data;
		next_sync_irq = 1'b0;
		next_special_irq = 1'b0;
		if (channel_init) begin
			next_locked = 1'b0;
			next_seen_one = 1'b0;
			next_run_hit = 1'b0;
			next_rx_cnt = 3'h0;
		end else if (bit_en) begin
			next_rx_shift = cand;
			next_rx_cnt = rx_cnt + 3'h1;
			if (!locked && is_sync && (single_sync_select || seen_one || rx_cnt != 3'h7)) begin
				// Candidate sync found while hunting, on or off the character grid: realign here
				next_rx_cnt = 3'h0;
				next_rx_valid = 1'b1; // [RULE_13]
				next_rx_data = cand;
				next_last_char = cand;
				next_run_hit = 1'b0;
				if (single_sync_select) begin
					next_locked = 1'b1;
					next_sync_irq = 1'b1; // [RULE_11] [RULE_15]
				end else if (seen_one && rx_cnt == 3'h7) begin
					next_locked = 1'b1;
					next_sync_irq = 1'b1; // [RULE_11] [RULE_14]
					// The locking sync is the second in a row, so it already validates the run
					next_special_irq = strip_sync_on; // [RULE_18]
					next_run_hit = strip_sync_on;
				end else begin
					next_seen_one = 1'b1;
				end
			end else if (rx_cnt == 3'h7) begin
				// Character boundary: junk before sync and data after are both passed
				next_rx_valid = 1'b1; // [RULE_13]
				next_rx_data = cand;
				if (!locked) begin
					next_seen_one = is_sync && !single_sync_select;
				end
				// Second in a row is passed and flagged; later repeats are dropped
				if (repeat_hit && run_hit) begin
					next_rx_valid = 1'b0; // [RULE_18] [RULE_19]
				end else if (repeat_hit) begin
					next_special_irq = 1'b1; // [RULE_18] [RULE_19]
					next_run_hit = 1'b1;
				end else begin
					next_run_hit = 1'b0;
				end
				next_last_char = cand;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rx_shift <= 8'h00;
			rx_cnt <= 3'h0;
			locked <= 1'b0;
			seen_one <= 1'b0;
			last_char <= 8'h00;
			run_hit <= 1'b0;
			rx_valid <= 1'b0;
			rx_data <= 8'h00;
			sync_irq <= 1'b0;
			special_irq <= 1'b0;
		end else begin
			rx_shift <= next_rx_shift;
			rx_cnt <= next_rx_cnt;
			locked <= next_locked;
			seen_one <= next_seen_one;
			last_char <= next_last_char;
			run_hit <= next_run_hit;
			rx_valid <= next_rx_valid;
			rx_data <= next_rx_data;
			sync_irq <= next_sync_irq;
			special_irq <= next_special_irq;
		end
	end
endmodule : exs_channel

// ==== tb/exs_channel_properties.sv ====
/*
 * Port-level checks for the sync channel: transmit handshake, request line, sync register, receive events.
 * Assumes one clock domain and nrst asynchronous, active low.
 */
`timescale 1ns/1ps
module exs_channel_properties
	import exs_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic channel_init,
	input wire logic escape_command_mode,
	input wire logic steady_state_detect_enable,
	input wire logic sync_wr,
	input wire logic [7:0] sync_wdata,
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire logic request_n,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic sync_irq,
	input wire logic special_irq,
	input wire logic [7:0] sync_char_register
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	chk_ready_pulse: assert property (tx_ready |=> !tx_ready)
		else $error("tx_ready held past one cycle");
	chk_ready_cause: assert property (tx_ready |-> $past(tx_valid))
		else $error("tx_ready without an offered byte");
	chk_init_load: assert property (channel_init && !sync_wr |=> sync_char_register == EXS_SYNC_CHAR)
		else $error("init did not reload sync value");
	chk_sync_write: assert property (sync_wr && !channel_init |=> sync_char_register == $past(sync_wdata))
		else $error("sync write not taken");
	chk_sync_hold: assert property (!sync_wr && !channel_init |=> $stable(sync_char_register))
		else $error("sync value changed by itself");
	chk_req_cause: assert property ($changed(request_n) |-> $past(escape_command_mode))
		else $error("request line moved outside escape mode");
	chk_lock_char: assert property (sync_irq |-> rx_valid && rx_data == sync_char_register)
		else $error("sync event not on a sync character");
	chk_irq_pulse: assert property (sync_irq |=> !sync_irq)
		else $error("sync event longer than one cycle");
	chk_rx_spacing: assert property (rx_valid |=> !rx_valid)
		else $error("characters delivered back to back");
	chk_special_gate: assert property (special_irq |-> $past(steady_state_detect_enable))
		else $error("special event without steady-state detect");
endmodule : exs_channel_properties

bind exs_channel exs_channel_properties u_props (.clk(clk), .nrst(nrst), .channel_init(channel_init),
	.escape_command_mode(escape_command_mode), .steady_state_detect_enable(steady_state_detect_enable),
	.sync_wr(sync_wr), .sync_wdata(sync_wdata), .tx_valid(tx_valid), .tx_ready(tx_ready),
	.request_n(request_n), .rx_valid(rx_valid), .rx_data(rx_data), .sync_irq(sync_irq),
	.special_irq(special_irq), .sync_char_register(sync_char_register));

// ==== tb/exs_line_model.sv ====
/*
 * Far end of the serial line: frames transmitted characters, plays queued receive characters.
 * Assumes bit_en marks each line bit and both directions run LSB first.
 */
`timescale 1ns/1ps
module exs_line_model (
	input wire logic clk,
	input wire logic nrst,
	input wire logic bit_en,
	input wire logic txd,
	output logic rxd
);
	logic [7:0] q[$];
	logic [7:0] sq[$];
	logic [7:0] sr;
	logic [7:0] so;
	logic lk;
	int nb;
	int ns;
	// Framing locks on the first idle fill, which has only one alignment
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sr = 8'hFF;
			so = 8'hFF;
			lk = 1'b0;
			nb = 0;
			ns = 0;
			rxd <= 1'b1;
		end else if (bit_en) begin
			sr = {txd, sr[7:1]};
			if (lk) nb = nb + 1;
			if (nb == 8 || (!lk && sr == 8'h16)) begin
				lk = 1'b1;
				nb = 0;
				q.push_back(sr);
			end
			rxd <= so[ns];
			ns = (ns + 1) % 8;
			// Mark fill keeps byte framing when nothing is queued
			if (ns == 0) so = (sq.size() > 0) ? sq.pop_front() : 8'hFF;
		end
	end
endmodule : exs_line_model

// ==== tb/tb.sv ====
/*
 * Self-checking bench: transparent and escape transmit, sync hunt, stripping, sync register.
 * Assumes the line model and the bound property checker.
 */
`timescale 1ns/1ps
module tb;
	import exs_pkg::*;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic bit_en = 1'b0;
	logic init = 1'b0;
	logic esc = 1'b0;
	logic ssd_en = 1'b0;
	logic sgl = 1'b0;
	logic strip = 1'b0;
	logic spc_en = 1'b0;
	logic swr = 1'b0;
	logic txv = 1'b0;
	logic [7:0] swd = 8'h00;
	logic [7:0] txb = 8'h00;
	logic [7:0] sp [EXS_SPECIAL_COUNT] = '{8'h07, 8'h08, 8'h09};
	logic tx_ready, txd, request_n, rxd, rx_valid, sync_irq, special_irq;
	logic [7:0] rx_data, sreg, v;
	logic [7:0] d[$];
	logic [8:0] rq[$];
	int errors = 0;
	int tests_run = 0;
	int nsy = 0;
	int nsp = 0;
	int bc = 0;
	int i;
	always #4 clk = ~clk;
	always @(posedge clk) begin
		bit_en <= (bc == 3);
		bc = (bc + 1) % 4;
		if (rx_valid === 1'b1) rq.push_back({sync_irq, rx_data});
		nsy += int'(sync_irq === 1'b1);
		nsp += int'(special_irq === 1'b1);
	end
	exs_channel dut (.clk(clk), .nrst(nrst), .bit_en(bit_en), .channel_init(init), .escape_command_mode(esc),
		.steady_state_detect_enable(ssd_en), .single_sync_select(sgl), .sync_strip_enable(strip),
		.special_char_detect_enable(spc_en), .special_char_values(sp), .sync_wr(swr), .sync_wdata(swd),
		.tx_valid(txv), .tx_data(txb), .tx_ready(tx_ready), .txd(txd), .request_n(request_n), .rxd(rxd),
		.rx_valid(rx_valid), .rx_data(rx_data), .sync_irq(sync_irq), .special_irq(special_irq),
		.sync_char_register(sreg));
	exs_line_model pm (.clk(clk), .nrst(nrst), .bit_en(bit_en), .txd(txd), .rxd(rxd));
	// ****************************************
	// Helpers
	// ****************************************
	task tally_and_finish();
		if (errors == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish
	task chk(input logic [7:0] a, input logic [7:0] e);
		tests_run++;
		if (a !== e) begin
			errors++;
			$display("ERROR %0t got %h expected %h", $time, a, e);
		end
	endtask : chk
	task hang();
		errors++;
		$display("ERROR %0t wait ran out", $time);
		tally_and_finish();
	endtask : hang
	function automatic int reps(input logic [7:0] n);
		return (n == 8'h00) ? 3 : int'(n);
	endfunction : reps
	task put(input logic [7:0] b);
		int n;
		@(posedge clk);
		txv <= 1'b1;
		txb <= b;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (tx_ready !== 1'b1 && n < 3000);
		txv <= 1'b0;
		if (n >= 3000) hang();
	endtask : put
	// Leading idle fill is dropped so the head is the first real character
	task gotx(input int n);
		int t;
		for (t = 0; t < 4000; t++) begin
			while (pm.q.size() > 0 && pm.q[0] === EXS_SYNC_CHAR) void'(pm.q.pop_front());
			if (pm.q.size() >= n) break;
			@(posedge clk);
		end
		if (t >= 4000) hang();
	endtask : gotx
	task esc_cmd(input logic [7:0] r, input logic [7:0] c, input logic [7:0] n, input logic nreq);
		pm.q.delete();
		put(EXS_CMD_START);
		put(r);
		put(c);
		put(n);
		if (n == 8'h00) put(8'h33);
		gotx(reps(n) + 1);
		for (i = 0; i < reps(n); i++) chk(pm.q[i], c);
		chk(pm.q[reps(n)], (n == 8'h00) ? 8'h33 : EXS_SYNC_CHAR);
		chk({7'h0, request_n}, {7'h0, nreq});
	endtask : esc_cmd
	task pulse_init();
		@(posedge clk);
		init <= 1'b1;
		@(posedge clk);
		init <= 1'b0;
	endtask : pulse_init
	task rxrun(input logic [7:0] b[$]);
		int t;
		rq.delete();
		nsy = 0;
		nsp = 0;
		pm.sq = b;
		for (t = 0; t < 4000; t++) begin
			if (rq.size() > 0 && rq[$][7:0] === 8'h3C) break;
			@(posedge clk);
		end
		if (t >= 4000) hang();
	endtask : rxrun
	task tail(input logic [7:0] s, input logic [7:0] e[$]);
		int j;
		j = 0;
		while (j < rq.size() && rq[j][8] !== 1'b1) j++;
		chk(8'(nsy), 8'h01);
		chk({7'h0, j > 0}, 8'h01);
		chk(rq[j][7:0], s);
		for (int k = 0; k < e.size(); k++) chk(rq[j + 1 + k][7:0], e[k]);
	endtask : tail
	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		void'($urandom(32'h6B00));
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		chk(sreg, EXS_SYNC_CHAR);
		repeat (200) @(posedge clk);
		pm.q.delete();
		for (i = 0; i < 6; i++) begin
			v = (i == 2) ? EXS_CMD_START : 8'($urandom);
			if (v == EXS_SYNC_CHAR) v = 8'h17;
			d.push_back(v);
			put(v);
		end
		gotx(7);
		for (i = 0; i < 6; i++) chk(pm.q[i], d[i]);
		chk(pm.q[6], EXS_SYNC_CHAR);
		esc <= 1'b1;
		esc_cmd(8'h01, 8'h80, 8'h01, 1'b0);
		esc_cmd(8'h02, 8'h66, 8'h02, 1'b0);
		v = 8'($urandom) | 8'h01;
		esc_cmd(8'h01, v, 8'($urandom % 4) + 8'h01, 1'b0);
		esc_cmd(8'h00, 8'hFF, 8'h00, 1'b1);
		esc <= 1'b0;
		strip <= 1'b1;
		spc_en <= 1'b1;
		pulse_init();
		rxrun('{8'h00, 8'hFF, 8'h16, 8'h5A, 8'h16, 8'h16, 8'h16, 8'h16, 8'h07, 8'h07, 8'h07, 8'h3C});
		tail(8'h16, '{8'h16, 8'h16, 8'h07, 8'h07, 8'h07, 8'h3C});
		chk(8'(nsp), 8'h00);
		ssd_en <= 1'b1;
		v = sp[$urandom % 3];
		pulse_init();
		rxrun('{8'h00, 8'hFF, 8'h16, 8'h16, 8'h16, 8'h16, v, v, v, v, 8'h3C});
		tail(8'h16, '{v, v, 8'h3C});
		chk(8'(nsp), 8'h02);
		ssd_en <= 1'b0;
		sgl <= 1'b1;
		pulse_init();
		@(posedge clk);
		swr <= 1'b1;
		swd <= 8'h5A;
		@(posedge clk);
		swr <= 1'b0;
		@(posedge clk);
		chk(sreg, 8'h5A);
		rxrun('{8'h00, 8'hFF, 8'h5A, 8'h21, 8'h3C});
		tail(8'h5A, '{8'h21, 8'h3C});
		pulse_init();
		@(posedge clk);
		chk(sreg, EXS_SYNC_CHAR);
		tally_and_finish();
	end
endmodule : tb
